// ==== design/dbg_access_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - programming key flag shown, self-clears when done
// - chip-erase key flag shown, self-clears when done
// - signature write asserts and holds system reset
// - any other value releases system reset
// - reset request reads bit0 active, rest zero
// - port logic stays out of system reset
// - clock select codes, default 4 MHz
// - debugger keeps 4 MHz unless top brown-out
// - done bit starts user row programming
// - done bit writable only with key
// - debugger writes done after data loaded
// - clock request bit requests system clock
// - clock request set on enable, cleared disable
// - reset-active status set in reset, read clears
// - asleep status mirrors system sleep
// - nvm permitted status; debugger resets after
// - user row permitted status; debugger writes done
// - lock status reads one while locked
// - crc status one-hot coded
// - disable restores 4 MHz clock select, clears keys, reset hold and clock request
module dbg_access_regs
    import dbg_access_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  srst,
    dbg_access_if.device link,
    input  wire logic  port_enable,
    input  wire logic  key_nvm_program,
    input  wire logic  key_chip_erase,
    input  wire logic  key_user_row,
    input  wire logic  nvm_program_done,
    input  wire logic  chip_erase_done,
    input  wire logic  system_in_reset,
    input  wire logic  system_in_sleep,
    input  wire logic  nvm_program_permitted,
    input  wire logic  user_row_program_permitted,
    input  wire logic  lock_bits_set,
    input  wire logic  crc_enabled,
    input  wire logic  crc_done,
    input  wire logic  crc_ok,
    output logic       system_reset_hold,
    output logic       system_clock_request,
    output logic [1:0] port_clock_select,
    output logic       user_row_done,
    output logic       user_row_key_flag,
    output logic       nvm_program_flag
);
    import dbg_access_pkg::*;

    logic       chip_erase_flag;
    logic       reset_active_reg;
    logic [7:0] status_reg;
    logic [2:0] crc_reg;
    logic       wr_hit;
    logic       rd_hit;
    logic [7:0] rdata_next;
    logic       port_enable_reg;

    // req stays high through the ack edge, so a request is taken once, on the edge before ack
    assign wr_hit = link.req & link.wr & ~link.ack;
    assign rd_hit = link.req & ~link.wr & ~link.ack;

    // ****************************************************************
    // key flags: set by decoder, cleared by disable; programming and chip-erase flags also by end of sequence
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst || !port_enable) begin
            nvm_program_flag  <= 1'b0;
            chip_erase_flag   <= 1'b0;
            user_row_key_flag <= 1'b0;
        end else begin
            // done wins over a key still asserted on the same edge
            if (nvm_program_done)
                nvm_program_flag <= 1'b0;
            else if (key_nvm_program)
                nvm_program_flag <= 1'b1;
            if (chip_erase_done)
                chip_erase_flag <= 1'b0;
            else if (key_chip_erase)
                chip_erase_flag <= 1'b1;
            if (key_user_row)
                user_row_key_flag <= 1'b1;
        end
    end

    // ****************************************************************
    // reset request; srst is the port's own reset, not the system's
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst || !port_enable) begin
            system_reset_hold <= 1'b0;
        end else if (wr_hit && link.addr == system_reset_request_off) begin
            // the hold drives an output and sets reset-active status; nothing here resets from it
            system_reset_hold <= (link.wdata == reset_signature);
        end
    end

    // ****************************************************************
    // port clock select and system control
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst || !port_enable) begin
            port_clock_select <= clk_sel_reset;
        end else if (wr_hit && link.addr == port_clock_control_off) begin
            port_clock_select <= link.wdata[1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst || !port_enable) begin
            system_clock_request <= 1'b0;
        end else if (wr_hit && link.addr == system_control_off) begin
            system_clock_request <= link.wdata[ctl_clock_req_bit];
        end else if (!port_enable_reg) begin
            system_clock_request <= 1'b1;
        end
    end

    // last cycle's enable; a fresh enable, after reset or a disable, raises the clock request once
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            port_enable_reg <= 1'b0;
        end else begin
            port_enable_reg <= port_enable;
        end
    end

    // done is a one-cycle start pulse; without the key the done bit is dropped, the clock request bit is still written
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            user_row_done <= 1'b0;
        end else begin
            user_row_done <= wr_hit && link.addr == system_control_off
                             && link.wdata[ctl_user_row_done_bit] && user_row_key_flag;
        end
    end

    // ****************************************************************
    // status: reset-active is sticky, a set beats the read clear
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            reset_active_reg <= 1'b0;
        end else if (system_in_reset || system_reset_hold) begin
            reset_active_reg <= 1'b1;
        end else if (rd_hit && link.addr == system_status_off) begin
            reset_active_reg <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_reg <= status_reset_value;
            crc_reg    <= crc_off;
        end else begin
            status_reg <= 8'h00;
            status_reg[st_reset_active_bit]  <= reset_active_reg;
            status_reg[st_asleep_bit]        <= system_in_sleep;
            status_reg[st_nvm_perm_bit]      <= nvm_program_permitted;
            status_reg[st_user_row_perm_bit] <= user_row_program_permitted;
            status_reg[st_locked_bit]        <= lock_bits_set;
            if (!crc_enabled)
                crc_reg <= crc_off;
            else if (!crc_done)
                crc_reg <= crc_busy;
            else
                crc_reg <= crc_ok ? crc_pass : crc_fail;
        end
    end

    // ****************************************************************
    // read mux; unmapped and reserved bits read zero
    // ****************************************************************
    always_comb begin
        rdata_next = 8'h00;
        unique case (link.addr)
            key_status_off: begin
                rdata_next[key_user_row_bit]    = user_row_key_flag;
                rdata_next[key_nvm_program_bit] = nvm_program_flag;
                rdata_next[key_chip_erase_bit]  = chip_erase_flag;
            end
            system_reset_request_off: rdata_next[0] = system_reset_hold;
            port_clock_control_off:   rdata_next[1:0] = port_clock_select;
            system_control_off:       rdata_next[ctl_clock_req_bit] = system_clock_request;
            system_status_off: begin
                rdata_next = status_reg;
                rdata_next[st_reset_active_bit] = reset_active_reg;
            end
            memory_check_status_off:  rdata_next[2:0] = crc_reg;
            default:                  rdata_next = 8'h00;
        endcase
    end

    // one-cycle answer to every request
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            link.ack   <= 1'b0;
            link.rdata <= 8'h00;
        end else begin
            link.ack   <= link.req & ~link.ack;
            link.rdata <= rdata_next;
        end
    end
endmodule // dbg_access_regs
`default_nettype wire

// ==== design/dbg_access_pkg.sv ====
package dbg_access_pkg;
    // ****************************************************************
    // register map of the access layer (byte offsets on the link)
    // ****************************************************************
    localparam logic [3:0] key_status_off          = 4'h7;
    localparam logic [3:0] system_reset_request_off = 4'h8;
    localparam logic [3:0] port_clock_control_off  = 4'h9;
    localparam logic [3:0] system_control_off      = 4'hA;
    localparam logic [3:0] system_status_off       = 4'hB;
    localparam logic [3:0] memory_check_status_off = 4'hC;

    // ****************************************************************
    // field positions and values
    // ****************************************************************
    localparam int key_chip_erase_bit   = 3;
    localparam int key_nvm_program_bit  = 4;
    localparam int key_user_row_bit     = 5;
    localparam int ctl_clock_req_bit    = 0;
    localparam int ctl_user_row_done_bit = 1;
    localparam int st_locked_bit        = 0;
    localparam int st_user_row_perm_bit = 2;
    localparam int st_nvm_perm_bit      = 3;
    localparam int st_asleep_bit        = 4;
    localparam int st_reset_active_bit  = 5;
    localparam logic [7:0] reset_signature     = 8'h59;
    localparam logic [1:0] clk_sel_reserved    = 2'h0;
    localparam logic [1:0] clk_sel_16mhz       = 2'h1;
    localparam logic [1:0] clk_sel_8mhz        = 2'h2;
    localparam logic [1:0] clk_sel_4mhz        = 2'h3;
    localparam logic [1:0] clk_sel_reset       = 2'h3;
    localparam logic [7:0] status_reset_value  = 8'h01;
    localparam logic [2:0] crc_off             = 3'h0;
    localparam logic [2:0] crc_busy            = 3'h1;
    localparam logic [2:0] crc_pass            = 3'h2;
    localparam logic [2:0] crc_fail            = 3'h4;

    // ****************************************************************
    // debugger-side apb registers (byte addresses)
    // ****************************************************************
    localparam logic [7:0] apb_cmd_off    = 8'h00;
    localparam logic [7:0] apb_wdata_off  = 8'h04;
    localparam logic [7:0] apb_rdata_off  = 8'h08;
    localparam logic [7:0] apb_status_off = 8'h0C;
    localparam int cmd_go_bit    = 8;
    localparam int cmd_write_bit = 9;
endpackage

// ==== design/dbg_access_if.sv ====
`timescale 1ns/1ns
`default_nettype none
// register-access link between debugger and access layer
interface dbg_access_if;
    logic       req;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       ack;
    modport device (input req, input wr, input addr, input wdata, output rdata, output ack);
    modport host   (output req, output wr, output addr, output wdata, input rdata, input ack);
endinterface
`default_nettype wire

// ==== design/dbg_access_host.sv ====
`timescale 1ns/1ns
`default_nettype none
// debugger end: software drives it over apb; it runs one link access per command
module dbg_access_host
    import dbg_access_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    dbg_access_if.host       link
);
    import dbg_access_pkg::*;

    typedef enum logic [1:0] {st_idle = 2'b00, st_req = 2'b01, st_wait = 2'b11} host_state_t;
    host_state_t state_reg;
    logic [7:0]  wdata_reg;
    logic [7:0]  rdata_reg;
    logic        busy;
    logic        apb_wr;

    assign apb_wr = psel & penable & pwrite & pready;
    assign busy   = (state_reg != st_idle);

    // ****************************************************************
    // apb slave: answers in the first access cycle
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~(paddr == apb_cmd_off || paddr == apb_wdata_off
                       || paddr == apb_rdata_off || paddr == apb_status_off);
            unique case (paddr)
                apb_wdata_off:  prdata <= {24'h00_0000, wdata_reg};
                apb_rdata_off:  prdata <= {24'h00_0000, rdata_reg};
                apb_status_off: prdata <= {31'h0000_0000, busy};
                default:        prdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst)
            wdata_reg <= 8'h00;
        else if (apb_wr && paddr == apb_wdata_off)
            wdata_reg <= pwdata[7:0];
    end

    // ****************************************************************
    // link sequencer; a command while busy is dropped
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_reg  <= st_idle;
            link.req   <= 1'b0;
            link.wr    <= 1'b0;
            link.addr  <= 4'h0;
            link.wdata <= 8'h00;
            rdata_reg  <= 8'h00;
        end else begin
            unique case (state_reg)
                st_idle: if (apb_wr && paddr == apb_cmd_off && pwdata[cmd_go_bit]) begin
                    link.req   <= 1'b1;
                    link.wr    <= pwdata[cmd_write_bit];
                    link.addr  <= pwdata[3:0];
                    link.wdata <= wdata_reg;
                    state_reg  <= st_req;
                end
                st_req: state_reg <= st_wait;
                st_wait: if (link.ack) begin
                    link.req  <= 1'b0;
                    rdata_reg <= link.rdata;
                    state_reg <= st_idle;
                end
            endcase
        end
    end
endmodule // dbg_access_host
`default_nettype wire

// ==== testbench/dbg_access_monitor.sv ====
`timescale 1ns/1ns
`default_nettype none
// ****************************************************************
// link checks: handshake timing and fixed bits of read answers
// ****************************************************************
module dbg_access_monitor
    import dbg_access_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic       req,
    input wire logic       wr,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // addr still holds at the ack edge, so the answer is judged there
    wire logic rd_ack = ack && !wr;
    ack_follows_req_a: assert property ($rose(req) |=> ack)
        else $error("link ack late");
    ack_needs_req_a: assert property (ack |-> req && $past(req))
        else $error("link ack without request");
    ack_pulse_a: assert property (ack |=> !ack && !req)
        else $error("link ack or request not released");
    req_hold_a: assert property (req && !ack |=> req && $stable(addr) && $stable(wdata))
        else $error("link request changed before ack");
    reset_request_field_read_a: assert property (rd_ack && addr == system_reset_request_off |-> rdata[7:1] == 7'h00)
        else $error("reset request upper bits set");
    key_rsvd_a: assert property (rd_ack && addr == key_status_off |-> rdata[7:6] == 2'h0 && rdata[2:0] == 3'h0)
        else $error("key status reserved bits set");
    ctrl_rsvd_a: assert property (rd_ack && addr == system_control_off |-> rdata[7:2] == 6'h00)
        else $error("system control reserved bits set");
    status_rsvd_a: assert property (rd_ack && addr == system_status_off |-> rdata[7:6] == 2'h0 && !rdata[1])
        else $error("status reserved bits set");
    crc_onehot_a: assert property (rd_ack && addr == memory_check_status_off |-> rdata[7:3] == 5'h00 && $onehot0(rdata[2:0]))
        else $error("memory check status not one-hot");
    clksel_rsvd_a: assert property (rd_ack && addr == port_clock_control_off |-> rdata[7:2] == 6'h00)
        else $error("clock control reserved bits set");
endmodule // dbg_access_monitor
`default_nettype wire

// ==== testbench/debug_access_system_regs_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module debug_access_system_regs_test;
    import dbg_access_pkg::*;
    logic sys_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic pen = 0, k_nvm = 0, k_ce = 0, k_ur = 0, d_nvm = 0, d_ce = 0, s_rst = 0, s_slp = 0;
    logic p_nvm = 0, p_ur = 0, lock = 1, c_en = 0, c_dn = 0, c_ok = 0;
    logic hold, creq, urd, ukf, nvf;
    logic [1:0] csel;
    int err_total = 0, checks_done = 0, cyc = 0, pulses = 0;
    dbg_access_if lnk();
    dbg_access_host i_dbg_access_host (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lnk));
    dbg_access_regs i_dbg_access_regs (.sys_clk(sys_clk), .srst(srst), .link(lnk), .port_enable(pen),
        .key_nvm_program(k_nvm), .key_chip_erase(k_ce), .key_user_row(k_ur), .nvm_program_done(d_nvm),
        .chip_erase_done(d_ce), .system_in_reset(s_rst), .system_in_sleep(s_slp),
        .nvm_program_permitted(p_nvm), .user_row_program_permitted(p_ur), .lock_bits_set(lock),
        .crc_enabled(c_en), .crc_done(c_dn), .crc_ok(c_ok), .system_reset_hold(hold),
        .system_clock_request(creq), .port_clock_select(csel), .user_row_done(urd),
        .user_row_key_flag(ukf), .nvm_program_flag(nvf));
    dbg_access_monitor i_dbg_access_monitor (.sys_clk(sys_clk), .srst(srst), .req(lnk.req), .wr(lnk.wr),
        .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
    // ****************************************************************
    // clock, hang guard and done-pulse counter
    // ****************************************************************
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (urd === 1'b1) pulses <= pulses + 1;
        if (cyc == 20000) begin
            err_total++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t %s got %h", $time, m, g);
        end
    endtask
    // one apb transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    // one link access through the command register, polled to completion
    task automatic lk(input logic w, input logic [3:0] a, input logic [7:0] d);
        if (w) apb(1, apb_wdata_off, {24'h00_0000, d});
        apb(1, apb_cmd_off, {22'h00_0000, w, 1'b1, 4'h0, a});
        do apb(0, apb_status_off, 32'h0000_0000); while (rd[0] !== 1'b0);
        if (!w) apb(0, apb_rdata_off, 32'h0000_0000);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string m);
        lk(0, a, 8'h00);
        chk(rd[7:0], e, m);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        chk(csel, clk_sel_4mhz, "clock select default");
        chk(creq, 1, "clock request on enable");
        rchk(system_status_off, status_reset_value, "status reset");
        rchk(system_control_off, 8'h01, "control reset");
        rchk(memory_check_status_off, crc_off, "crc off");
        lk(1, system_status_off, 8'hFE);
        rchk(system_status_off, 8'h01, "status ignores write");
        apb(0, 8'h10, 32'h0000_0000);
        chk(err, 1, "unmapped address");
        $display("test reset done");
    endtask
    task automatic t_reset_request_field();
        lk(1, system_reset_request_off, reset_signature);
        chk(hold, 1, "reset held");
        s_rst <= 1;
        rchk(system_reset_request_off, 8'h01, "request reads one");
        rchk(system_status_off, 8'h21, "reset active");
        rchk(system_status_off, 8'h21, "set wins over read");
        lk(1, system_reset_request_off, 8'h58);
        chk(hold, 0, "reset released");
        s_rst <= 0;
        rchk(system_reset_request_off, 8'h00, "request reads zero");
        rchk(system_status_off, 8'h21, "sticky reset seen");
        rchk(system_status_off, 8'h01, "cleared by read");
        $display("test reset request done");
    endtask
    task automatic t_clk();
        logic [1:0] codes[4] = '{clk_sel_16mhz, clk_sel_8mhz, clk_sel_reserved, clk_sel_4mhz};
        foreach (codes[i]) begin
            lk(1, port_clock_control_off, {6'h00, codes[i]});
            chk(csel, codes[i], "clock select");
            rchk(port_clock_control_off, {6'h00, codes[i]}, "clock select read");
        end
        lk(1, system_control_off, 8'h00);
        chk(creq, 0, "clock request withdrawn");
        lk(1, system_control_off, 8'h01);
        chk(creq, 1, "clock request raised");
        $display("test clock done");
    endtask
    task automatic t_keys();
        lk(1, system_control_off, 8'h03);
        chk(pulses, 0, "done ignored without key");
        k_ur <= 1; k_nvm <= 1; k_ce <= 1; p_ur <= 1; p_nvm <= 1; s_slp <= 1; lock <= 0;
        rchk(key_status_off, 8'h38, "keys shown");
        chk(ukf & nvf, 1, "key flags");
        rchk(system_status_off, 8'h1C, "status mirrors");
        lk(1, system_control_off, 8'h03);
        chk(pulses, 1, "done starts programming");
        k_nvm <= 0; k_ce <= 0; d_nvm <= 1; d_ce <= 1;
        @(posedge sys_clk);
        d_nvm <= 0; d_ce <= 0;
        rchk(key_status_off, 8'h20, "keys self-clear");
        $display("test keys done");
    endtask
    task automatic t_crc();
        logic [2:0] ins[4] = '{3'b000, 3'b100, 3'b111, 3'b110};
        logic [2:0] exp[4] = '{crc_off, crc_busy, crc_pass, crc_fail};
        foreach (ins[i]) begin
            {c_en, c_dn, c_ok} <= ins[i];
            rchk(memory_check_status_off, {5'h00, exp[i]}, "crc status");
        end
        $display("test crc done");
    endtask
    task automatic t_disable();
        lk(1, port_clock_control_off, {6'h00, clk_sel_16mhz});
        lk(1, system_reset_request_off, reset_signature);
        @(posedge sys_clk);
        pen <= 0;
        repeat (2) @(posedge sys_clk);
        chk({creq, hold, ukf, nvf}, 0, "disable clears");
        chk(csel, clk_sel_4mhz, "disable restores select");
        pen <= 1;
        repeat (2) @(posedge sys_clk);
        chk(creq, 1, "enable requests clock");
        $display("test disable done");
    endtask
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 0;
        pen <= 1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_reset_request_field();
        t_clk();
        t_keys();
        t_crc();
        t_disable();
        complete_run();
    end
endmodule // debug_access_system_regs_test
`default_nettype wire
